//--- irq_pend_pkg.sv
// constants for the pending / active flag block: register map, source layout, event bits.
// assumes a 12-bit byte address on the register port and 32-bit data.
package irq_pend_pkg;

  localparam int unsigned NUM_SRC = 39;
  localparam int unsigned ID_W = 6;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // implemented sources: 2, 3, 12, 14, 16..38
  localparam logic [NUM_SRC-1:0] SRC_IMPL_MASK = 39'h7f_ffff_500c;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_PEND_SET_LOWER = 12'h200;
  localparam logic [ADDR_W-1:0] OFF_PEND_SET_UPPER = 12'h204;
  localparam logic [ADDR_W-1:0] OFF_PEND_CLEAR_LOWER = 12'h280;
  localparam logic [ADDR_W-1:0] OFF_PEND_CLEAR_UPPER = 12'h284;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE_STATUS_LOWER = 12'h300;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE_STATUS_UPPER = 12'h304;
  localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 12'h380;
  localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 12'h384;

  // field positions
  localparam int unsigned UPPER_LSB = 32;
  localparam int unsigned UPPER_W = 7;
  localparam int unsigned HI16_LSB = 16;
  localparam int unsigned SRC_12 = 12;
  localparam int unsigned SRC_14 = 14;
  localparam int unsigned LO2_LSB = 2;

  // event status bits
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_TAKE = 0;
  localparam int unsigned EV_RETIRE = 1;
  localparam int unsigned EV_RET_STRAY = 2;
  localparam int unsigned EV_SW_SET = 3;

  // reset values
  localparam logic [NUM_SRC-1:0] FLAGS_RST = 39'h00_0000_0000;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

endpackage

//--- irq_flag_if.sv
// carrier between the register front end and the flag bank.
// assumes one clock domain; the bank owns the flag state.
`timescale 1ns/1ps
`default_nettype none
interface irq_flag_if #(
  parameter int unsigned W = 39
);
  logic [W-1:0] set_vec;
  logic [W-1:0] clr_vec;
  logic [W-1:0] take_vec;
  logic [W-1:0] ret_vec;
  logic [W-1:0] pend_vec;
  logic [W-1:0] act_vec;

  modport ctrl (output set_vec, output clr_vec, output take_vec, output ret_vec, input pend_vec, input act_vec);
  modport bank (input set_vec, input clr_vec, input take_vec, input ret_vec, output pend_vec, output act_vec);
endinterface
`default_nettype wire

//--- irq_flag_bank.sv
// pending and active flags, one pair per source, only where implemented.
// assumes set/clear/take/retire vectors are single-cycle and already masked.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_bank #(
  parameter int unsigned W = 39,
  parameter logic [W-1:0] IMPL = '1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  irq_flag_if.bank fl
);
  logic [W-1:0] pend_q;
  logic [W-1:0] pend_d;
  logic [W-1:0] act_q;
  logic [W-1:0] act_d;

  // a software set beats any clear, including the one from acceptance
  assign pend_d = ((pend_q & ~fl.clr_vec & ~fl.take_vec) | fl.set_vec) & IMPL;
  // acceptance beats retirement so a re-entered source stays active
  assign act_d = ((act_q & ~fl.ret_vec) | fl.take_vec) & IMPL;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_q <= RST;
      act_q <= RST;
    end else begin
      pend_q <= pend_d;
      act_q <= act_d;
    end
  end

  assign fl.pend_vec = pend_q;
  assign fl.act_vec = act_q;
endmodule
`default_nettype wire

//--- interrupt_pending_active_logic.sv
// pending / in-service flag logic of the fast interrupt controller, with register port and event irq.
// assumes a synchronous register master (one-cycle strobes) and a core that
// reports acceptance and return with a source number.
//
// Contract
// - ones in bits 31..16 of the low set register make sources 16..31 pending.
// - ones in bits 14 and 12 of the low set register pend sources 14, 12.
// - ones in bits 3 and 2 of the low set register pend sources 3, 2.
// - bits 6..0 of the high set register pend sources 32..38; zeros ignored.
// - ones in bits 31..16 of the low clear register unpend sources 16..31.
// - ones in bits 12 and 14 of the low clear register unpend sources 12, 14.
// - ones in bits 2 and 3 of the low clear register unpend sources 2, 3.
// - bits 6..0 of the high clear register unpend sources 32..38; zeros ignored.
// - low active register bits 31..16 show sources 16..31 in service, read only.
// - low active register bits 14 and 12 show sources 14, 12 in service.
// - low active register bits 3 and 2 show sources 3, 2 in service.
// - high active register bits 6..0 show sources 32..38 in service.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module interrupt_pending_active_logic (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [irq_pend_pkg::ADDR_W-1:0] addr,
  input wire logic [irq_pend_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [irq_pend_pkg::DATA_W-1:0] rdata,
  input wire logic take_valid,
  input wire logic [irq_pend_pkg::ID_W-1:0] take_id,
  input wire logic ret_valid,
  input wire logic [irq_pend_pkg::ID_W-1:0] ret_id,
  output logic [irq_pend_pkg::NUM_SRC-1:0] pending,
  output logic [irq_pend_pkg::NUM_SRC-1:0] active,
  output logic irq
);
  import irq_pend_pkg::*;

  irq_flag_if #(.W(NUM_SRC)) fl ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  logic hit_set_lo;
  logic hit_set_hi;
  logic hit_clr_lo;
  logic hit_clr_hi;
  logic hit_act_lo;
  logic hit_act_hi;
  logic hit_ev_st;
  logic hit_ev_mask;

  assign hit_set_lo = (addr == OFF_PEND_SET_LOWER);
  assign hit_set_hi = (addr == OFF_PEND_SET_UPPER);
  assign hit_clr_lo = (addr == OFF_PEND_CLEAR_LOWER);
  assign hit_clr_hi = (addr == OFF_PEND_CLEAR_UPPER);
  assign hit_act_lo = (addr == OFF_ACTIVE_STATUS_LOWER);
  assign hit_act_hi = (addr == OFF_ACTIVE_STATUS_UPPER);
  assign hit_ev_st = (addr == OFF_EVENT_STATUS);
  assign hit_ev_mask = (addr == OFF_EVENT_MASK);

  logic wr_set_lo;
  logic wr_set_hi;
  logic wr_clr_lo;
  logic wr_clr_hi;
  logic wr_ev_st;
  logic wr_ev_mask;

  assign wr_set_lo = wr_en & hit_set_lo;
  assign wr_set_hi = wr_en & hit_set_hi;
  assign wr_clr_lo = wr_en & hit_clr_lo;
  assign wr_clr_hi = wr_en & hit_clr_hi;
  assign wr_ev_st = wr_en & hit_ev_st;
  assign wr_ev_mask = wr_en & hit_ev_mask;

  ////////////////////////////////////////////////////////////////////////////
  // software set / clear vectors, field by field

  logic [NUM_SRC-1:0] sw_set;
  logic [NUM_SRC-1:0] sw_clr;
  logic [15:0] set_hi16;
  logic set_12;
  logic set_14;
  logic [1:0] set_lo2;
  logic [UPPER_W-1:0] set_upper;
  logic [15:0] clr_hi16;
  logic clr_12;
  logic clr_14;
  logic [1:0] clr_lo2;
  logic [UPPER_W-1:0] clr_upper;

  // zero bits fall out of the or-in, so they leave the flags alone
  assign set_hi16 = wr_set_lo ? wdata[HI16_LSB +: 16] : 16'h0000;
  assign set_14 = wr_set_lo & wdata[SRC_14];
  assign set_12 = wr_set_lo & wdata[SRC_12];
  assign set_lo2 = wr_set_lo ? wdata[LO2_LSB +: 2] : 2'h0;
  assign set_upper = wr_set_hi ? wdata[UPPER_W-1:0] : 7'h00;

  assign clr_hi16 = wr_clr_lo ? wdata[HI16_LSB +: 16] : 16'h0000;
  assign clr_14 = wr_clr_lo & wdata[SRC_14];
  assign clr_12 = wr_clr_lo & wdata[SRC_12];
  assign clr_lo2 = wr_clr_lo ? wdata[LO2_LSB +: 2] : 2'h0;
  assign clr_upper = wr_clr_hi ? wdata[UPPER_W-1:0] : 7'h00;

  // reserved and unimplemented positions never reach the bank
  assign sw_set = {set_upper, set_hi16, 1'b0, set_14, 1'b0, set_12, 8'h00, set_lo2, 2'b00}
                  & SRC_IMPL_MASK;
  assign sw_clr = {clr_upper, clr_hi16, 1'b0, clr_14, 1'b0, clr_12, 8'h00, clr_lo2, 2'b00}
                  & SRC_IMPL_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // core acceptance and return

  logic [NUM_SRC-1:0] take_1hot;
  logic [NUM_SRC-1:0] ret_1hot;
  logic take_ok;
  logic ret_hit;

  // out-of-range numbers shift past the top and vanish
  assign take_1hot = take_valid ? (NUM_SRC'(1) << take_id) & SRC_IMPL_MASK : '0;
  assign ret_1hot = ret_valid ? (NUM_SRC'(1) << ret_id) & SRC_IMPL_MASK : '0;
  assign take_ok = |take_1hot;
  // a return for a source that is not in service is flagged, not acted on
  assign ret_hit = |(ret_1hot & fl.act_vec);

  ////////////////////////////////////////////////////////////////////////////
  // flag bank

  assign fl.set_vec = sw_set;
  assign fl.clr_vec = sw_clr;
  assign fl.take_vec = take_1hot;
  assign fl.ret_vec = ret_1hot;

  irq_flag_bank #(
    .W(NUM_SRC),
    .IMPL(SRC_IMPL_MASK),
    .RST(FLAGS_RST)
  ) u_bank (
    .clk(clk),
    .rst_n(rst_n),
    .fl(fl.bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // events, mask, interrupt line

  logic [EV_W-1:0] ev_hit;
  logic [EV_W-1:0] ev_st_q;
  logic [EV_W-1:0] ev_st_d;
  logic [EV_W-1:0] ev_mask_q;
  logic [EV_W-1:0] ev_mask_d;
  logic irq_q;
  logic irq_d;

  assign ev_hit[EV_TAKE] = take_ok;
  assign ev_hit[EV_RETIRE] = ret_hit;
  assign ev_hit[EV_RET_STRAY] = ret_valid & ~ret_hit;
  assign ev_hit[EV_SW_SET] = |sw_set;

  // write-one-to-clear, but a new event in the same cycle survives
  assign ev_st_d = (ev_st_q & ~(wr_ev_st ? wdata[EV_W-1:0] : EV_RST)) | ev_hit;
  assign ev_mask_d = wr_ev_mask ? wdata[EV_W-1:0] : ev_mask_q;
  // registered from the next status and mask, so the line changes in the same cycle as the status bit
  assign irq_d = |(ev_st_d & ev_mask_d);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev_st_q <= EV_RST;
      ev_mask_q <= EV_RST;
      irq_q <= 1'b0;
    end else begin
      ev_st_q <= ev_st_d;
      ev_mask_q <= ev_mask_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [DATA_W-1:0] act_lo_word;
  logic [DATA_W-1:0] act_hi_word;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  assign act_lo_word[HI16_LSB +: 16] = fl.act_vec[HI16_LSB +: 16];
  assign act_lo_word[15] = 1'b0;
  assign act_lo_word[SRC_14] = fl.act_vec[SRC_14];
  assign act_lo_word[13] = 1'b0;
  assign act_lo_word[SRC_12] = fl.act_vec[SRC_12];
  assign act_lo_word[11:4] = 8'h00;
  assign act_lo_word[LO2_LSB +: 2] = fl.act_vec[LO2_LSB +: 2];
  assign act_lo_word[1:0] = 2'b00;
  assign act_hi_word = {25'h000_0000, fl.act_vec[UPPER_LSB +: UPPER_W]};

  // write-only set/clear registers and unmapped addresses all read zero
  assign rd_mux = hit_act_lo ? act_lo_word :
                  hit_act_hi ? act_hi_word :
                  hit_ev_st ? {28'h000_0000, ev_st_q} :
                  hit_ev_mask ? {28'h000_0000, ev_mask_q} :
                  RDATA_RST;
  // data stand only in the cycle after the strobe
  assign rdata_d = rd_en ? rd_mux : RDATA_RST;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata = rdata_q;
  assign pending = fl.pend_vec;
  assign active = fl.act_vec;
  assign irq = irq_q;

endmodule
`default_nettype wire

//--- irq_pend_checker_assertions.sv
// concurrent checks on the pending / active flag block, seen from its top ports.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module irq_pend_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic take_valid,
  input wire logic [5:0] take_id,
  input wire logic ret_valid,
  input wire logic [5:0] ret_id,
  input wire logic [38:0] pending,
  input wire logic [38:0] active,
  input wire logic irq
);
  import irq_pend_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire w_sl = wr_en && addr == OFF_PEND_SET_LOWER;
  wire w_su = wr_en && addr == OFF_PEND_SET_UPPER;
  wire w_cl = wr_en && addr == OFF_PEND_CLEAR_LOWER;
  wire w_cu = wr_en && addr == OFF_PEND_CLEAR_UPPER;
  // a write in the same cycle may re-pend the source, so leave it out
  wire tk = take_valid && take_id < 6'd39 && SRC_IMPL_MASK[take_id] && !wr_en;
  wire rt = ret_valid && ret_id < 6'd39 && !(take_valid && take_id == ret_id);
  ////////////////
  property p_set_lo;
    w_sl |=> (pending[31:0] & $past(wdata)) == ($past(wdata) & SRC_IMPL_MASK[31:0]);
  endproperty
  a_set_lo: assert property (p_set_lo) else $error("set lower missed");
  property p_set_up;
    w_su |=> (pending[38:32] & $past(wdata[6:0])) == $past(wdata[6:0]);
  endproperty
  a_set_up: assert property (p_set_up) else $error("set upper missed");
  property p_clr_lo;
    w_cl |=> (pending[31:0] & $past(wdata)) == 32'h0000_0000;
  endproperty
  a_clr_lo: assert property (p_clr_lo) else $error("clear lower missed");
  property p_clr_up;
    w_cu |=> (pending[38:32] & $past(wdata[6:0])) == 7'h00;
  endproperty
  a_clr_up: assert property (p_clr_up) else $error("clear upper missed");
  property p_impl;
    ((pending | active) & ~SRC_IMPL_MASK) == 39'h00_0000_0000;
  endproperty
  a_impl: assert property (p_impl) else $error("flag on absent source");
  property p_take;
    tk |=> active[$past(take_id)] && !pending[$past(take_id)];
  endproperty
  a_take: assert property (p_take) else $error("accept not applied");
  property p_ret;
    rt |=> !active[$past(ret_id)];
  endproperty
  a_ret: assert property (p_ret) else $error("return not applied");
  property p_rd_lo;
    rd_en && addr == OFF_ACTIVE_STATUS_LOWER |=> rdata == $past(active[31:0]);
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("active lower read wrong");
  property p_rd_up;
    rd_en && addr == OFF_ACTIVE_STATUS_UPPER |=> rdata == 32'($past(active[38:32]));
  endproperty
  a_rd_up: assert property (p_rd_up) else $error("active upper read wrong");
  property p_rd_wo;
    (!rd_en || addr == OFF_PEND_SET_LOWER) |=> rdata == 32'h0000_0000;
  endproperty
  a_rd_wo: assert property (p_rd_wo) else $error("read data not zero");
  property p_irq_mask;
    wr_en && addr == OFF_EVENT_MASK && wdata[EV_W-1:0] == 4'h0 |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq high with all events masked");
endmodule
bind interrupt_pending_active_logic irq_pend_checker u_chk (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en,
  .rdata, .take_valid, .take_id, .ret_valid, .ret_id, .pending, .active, .irq);
`default_nettype wire

//--- core_model.sv
// behavioural core: accepts the lowest pending source, returns after a delay.
// assumes go, stray and hold are driven by the bench between edges.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic stray,
  input wire logic [3:0] hold,
  input wire logic [38:0] pending,
  output logic take_valid,
  output logic [5:0] take_id,
  output logic ret_valid,
  output logic [5:0] ret_id
);
  logic busy_q;
  logic [4:0] cnt_q;
  logic [5:0] id_q;
  always @(posedge clk) begin
    logic [5:0] n;
    n = 6'h00;
    take_valid <= 1'b0;
    ret_valid <= 1'b0;
    // idle ids toggle so a stale value is never mistaken for a request
    take_id <= ~take_id;
    ret_id <= ~ret_id;
    if (!rst_n) begin
      busy_q <= 1'b0;
      take_id <= 6'h00;
      ret_id <= 6'h00;
    end else if (stray) begin
      ret_valid <= 1'b1; // return of a source that never ran
      ret_id <= 6'h01;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 5'h01;
      if (cnt_q == 5'h00) begin
        busy_q <= 1'b0;
        ret_valid <= 1'b1; // leave the handler
        ret_id <= id_q;
      end
    end else if (go && |pending) begin
      for (int i = 38; i >= 0; i--) begin
        if (pending[i]) n = 6'(i);
      end
      busy_q <= 1'b1;
      take_valid <= 1'b1; // accept the lowest pending source
      take_id <= n;
      id_q <= n;
      cnt_q <= 5'h0a + 5'(hold);
    end
  end
endmodule
`default_nettype wire

//--- interrupt_pending_active_logic_bench.sv
// self-checking bench for the pending / active flag block with a behavioural core.
// assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module interrupt_pending_active_logic_bench;
  import irq_pend_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic go = 1'b0;
  logic stray = 1'b0;
  logic [3:0] hold = 4'h0;
  logic [31:0] rdata, d, seed;
  logic take_valid, ret_valid, irq;
  logic [5:0] take_id, ret_id;
  logic [38:0] pending, active, pe, e;
  logic [11:0] a;
  logic [11:0] ops [4] = '{OFF_PEND_SET_LOWER, OFF_PEND_SET_UPPER, OFF_PEND_CLEAR_LOWER, OFF_PEND_CLEAR_UPPER};
  int srcs [8] = '{2, 3, 12, 14, 16, 31, 32, 38};
  int num_errors = 0;
  int tests_run = 0;
  interrupt_pending_active_logic dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .take_valid(take_valid), .take_id(take_id), .ret_valid(ret_valid),
    .ret_id(ret_id), .pending(pending), .active(active), .irq(irq));
  core_model u_core (.clk(clk), .rst_n(rst_n), .go(go), .stray(stray), .hold(hold), .pending(pending),
    .take_valid(take_valid), .take_id(take_id), .ret_valid(ret_valid), .ret_id(ret_id));
  ////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [38:0] nxt(logic [38:0] p, logic [11:0] ad, logic [31:0] v);
    logic [38:0] m;
    m = ad[2] ? {v[6:0], 32'h0000_0000} : {7'h00, v};
    return ad[7] ? (p & ~m) : (p | (m & SRC_IMPL_MASK));
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [38:0] got, input logic [38:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: irq %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= ad;
    wdata <= v;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [11:0] ad, input logic [31:0] v);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk_rd(rdata, v);
  endtask
  // bounded wait on one in-service flag
  task automatic wait_act(input int n, input logic v);
    int k;
    for (k = 0; k < 60 && active[n] !== v; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 60) begin
      num_errors++;
      $display("Error at %0t: core link stuck", $time);
      wrap_up();
    end
  endtask
  ////////////////
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    seed = 32'h0000_30ee;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk(pending | active, 39'h00_0000_0000);
    chk_irq(irq, 1'b0);
    $display("reset test done");
    pe = '0;
    for (int j = 0; j < 40; j++) begin
      d = j < 2 ? 32'hffff_ffff : j < 4 ? 32'h0000_0000 : xs();
      a = ops[j < 4 ? j : xs() % 4];
      wr(a, d);
      pe = nxt(pe, a, d);
      chk(pending, pe);
    end
    wr(12'h3fc, 32'hffff_ffff);
    chk(pending, pe);
    rdc(12'h3fc, 32'h0000_0000);
    rdc(OFF_PEND_SET_LOWER, 32'h0000_0000);
    wr(OFF_PEND_CLEAR_LOWER, 32'hffff_ffff);
    wr(OFF_PEND_CLEAR_UPPER, 32'h0000_007f);
    $display("register test done");
    go <= 1'b1;
    foreach (srcs[k]) begin
      hold <= 4'(xs());
      wr(srcs[k] < 32 ? OFF_PEND_SET_LOWER : OFF_PEND_SET_UPPER, 32'h0000_0001 << srcs[k][4:0]);
      wait_act(srcs[k], 1'b1);
      chk(pending, 39'h00_0000_0000);
      e = 39'h00_0000_0001 << srcs[k];
      rdc(OFF_ACTIVE_STATUS_LOWER, e[31:0]);
      rdc(OFF_ACTIVE_STATUS_UPPER, {25'h000_0000, e[38:32]});
      wait_act(srcs[k], 1'b0);
      chk(active, 39'h00_0000_0000);
    end
    go <= 1'b0;
    $display("core test done");
    rdc(OFF_EVENT_STATUS, 32'h0000_000b);
    chk_irq(irq, 1'b0);
    wr(OFF_EVENT_MASK, 32'h0000_000f);
    chk_irq(irq, 1'b1);
    wr(OFF_EVENT_STATUS, 32'h0000_000f);
    chk_irq(irq, 1'b0);
    @(posedge clk);
    stray <= 1'b1;
    @(posedge clk);
    stray <= 1'b0;
    @(posedge clk);
    #1 chk_irq(irq, 1'b1);
    rdc(OFF_EVENT_STATUS, 32'h0000_0004);
    wr(OFF_EVENT_MASK, 32'h0000_0000);
    chk_irq(irq, 1'b0);
    $display("event test done");
    wrap_up();
  end
endmodule
`default_nettype wire
